// File: design/pwm_cycle_length_config.sv
// Shared PWM cycle configuration register of the counter array.
// Assumes a byte register port on core_clk and counter bits from the same domain.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cycle_consts.svh"
// Functional notes
// R1: Reload select steers compare addresses to capture/compare or auto-reload registers.
// R2: Auto-reload values act only in 9, 10 or 11-bit PWM.
// R3: Flag with enable set raises counter array interrupt; enable low blocks it.
// R4: Flag sets on overflow of counter bit chosen by length select.
// R5: Flag set by hardware or software write of 1; only software clears.
// R6: Bits four to two read zero; writes ignored.
// R7: Length select 00, 01, 10 give 8, 9, 10 bit cycles.
// R8: Length applies to non-wide PWM channels; wide channels ignore it.
// R9: Per-channel wide select picks 8-11 bit family or 16-bit PWM.
// R10: Length select 11 gives an 11-bit cycle.
module pwm_cycle_length_config
  import pwm_cycle_pkg::*;
#(
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Counter and channel modes
  input wire logic [15:0] counter_value,
  input wire logic counter_tick,
  input wire logic [NCH-1:0] chan_pwm_en,
  input wire logic [NCH-1:0] wide_pwm_select,
  // Outputs to channels and interrupt logic
  output logic reload_reg_select,
  output logic [1:0] cycle_length_select,
  output logic [NCH-1:0][3:0] chan_cycle_bits,
  output logic [NCH-1:0] chan_reload_used,
  output logic cycle_ovf,
  output logic cycle_ovf_irq
);
  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [7:0] CFG_ADDR = `PWM_CFG_ADDR;
  localparam logic [7:0] CFG_RESET = `PWM_CFG_RESET;
  // Writable bits; the unused middle bits never reach a register
  localparam logic [7:0] CFG_WMASK = `PWM_CFG_WMASK;
  localparam int SEL_BIT = `BIT_RELOAD_SEL;
  localparam int IEN_BIT = `BIT_OVF_IRQ_EN;
  localparam int FLAG_BIT = `BIT_OVF_FLAG;
  localparam int LEN_HI = `CLSEL_HI;
  localparam int LEN_LO = `CLSEL_LO;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == CFG_ADDR);
  endfunction

  // Carry out of the top bit of the selected cycle on one counter step
  function automatic logic carry_out(input logic [15:0] cnt, input cycle_len_t len);
    case (len)
      len_8bit: begin
        carry_out = &cnt[7:0]; // R7
      end
      len_9bit: begin
        carry_out = &cnt[8:0]; // R7
      end
      len_10bit: begin
        carry_out = &cnt[9:0]; // R7
      end
      len_11bit: begin
        carry_out = &cnt[10:0]; // R10
      end
      default: begin
        carry_out = 1'b0;
      end
    endcase
  endfunction

  // Register byte as software sees it; unused bits are constant zero
  function automatic logic [7:0] cfg_byte(input logic sel, input logic ien, input logic flg,
    input logic [1:0] len);
    cfg_byte = 8'h00; // R6
    cfg_byte[SEL_BIT] = sel;
    cfg_byte[IEN_BIT] = ien;
    cfg_byte[FLAG_BIT] = flg;
    cfg_byte[LEN_HI:LEN_LO] = len;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic cfg_sel;
  logic cfg_wr;
  logic [7:0] wr_bits;

  assign cfg_sel = addr_hit(reg_addr);
  assign cfg_wr = reg_wr && cfg_sel;
  assign wr_bits = reg_wdata & CFG_WMASK; // R6

  // ----------------------------------------
  // Reload select
  // ----------------------------------------
  logic reload_sel_q;
  logic reload_sel_d;

  always_comb begin
    reload_sel_d = reload_sel_q;
    if (cfg_wr) begin
      reload_sel_d = wr_bits[SEL_BIT]; // R1
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_sel_q <= CFG_RESET[SEL_BIT];
    end else begin
      reload_sel_q <= reload_sel_d;
    end
  end

  // ----------------------------------------
  // Overflow interrupt enable
  // ----------------------------------------
  logic irq_en_q;
  logic irq_en_d;

  always_comb begin
    irq_en_d = irq_en_q;
    if (cfg_wr) begin
      irq_en_d = wr_bits[IEN_BIT]; // R3
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q <= CFG_RESET[IEN_BIT];
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // ----------------------------------------
  // Cycle length select
  // ----------------------------------------
  logic [1:0] len_q;
  logic [1:0] len_d;

  always_comb begin
    len_d = len_q;
    if (cfg_wr) begin
      len_d = wr_bits[LEN_HI:LEN_LO]; // R7 R10
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      len_q <= CFG_RESET[LEN_HI:LEN_LO];
    end else begin
      len_q <= len_d;
    end
  end

  // ----------------------------------------
  // Cycle overflow
  // ----------------------------------------
  cycle_len_t len_now;
  logic ovf_evt;
  logic flag_q;
  logic flag_d;

  assign len_now = cycle_len_t'(len_q);
  // Counter value is the one before the step, so a full low field means carry
  assign ovf_evt = counter_tick && carry_out(counter_value, len_now); // R4

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (ovf_evt) begin
      flag_d = 1'b1; // R4 R5
    end else if (cfg_wr) begin
      flag_d = wr_bits[FLAG_BIT]; // R5
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= CFG_RESET[FLAG_BIT];
    end else begin
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // Level request; it drops as soon as software clears the flag
  logic irq_req;

  assign irq_req = flag_q && irq_en_q; // R3

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Reads are combinational so a read is answered in its own cycle
  always_comb begin
    reg_rdata = 8'h00;
    if (cfg_sel) begin
      reg_rdata = cfg_byte(reload_sel_q, irq_en_q, flag_q, len_q); // R6
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reload_reg_select = reload_sel_q; // R1
  assign cycle_length_select = len_q; // R7
  assign cycle_ovf = flag_q; // R5
  assign cycle_ovf_irq = irq_req; // R3

  // ----------------------------------------
  // Channel decode
  // ----------------------------------------
  // Per-channel decode sits in its own module so more channels cost no edits here
  chan_cfg_if #(.NCH(NCH)) ch_if ();

  assign ch_if.len_sel = len_q; // R8
  assign ch_if.wide_sel = wide_pwm_select; // R9
  assign ch_if.pwm_en = chan_pwm_en; // R2
  assign chan_cycle_bits = ch_if.cycle_bits; // R8 R9
  assign chan_reload_used = ch_if.reload_used; // R2

  chan_cycle #(.NCH(NCH)) u_chan (
    .cfg(ch_if.chan)
  );
endmodule
`default_nettype wire

// File: design/pwm_cycle_consts.svh
// Constants for the counter array PWM cycle configuration block.
// Assumes inclusion by bare name from design files.
`ifndef PWM_CYCLE_CONSTS_SVH
`define PWM_CYCLE_CONSTS_SVH
`define PWM_CFG_ADDR 8'hf7
`define PWM_CFG_RESET 8'h00
`define PWM_CFG_WMASK 8'he3
`define BIT_RELOAD_SEL 7
`define BIT_OVF_IRQ_EN 6
`define BIT_OVF_FLAG 5
`define CLSEL_HI 1
`define CLSEL_LO 0
`define BASE_CYCLE_BITS 8
`endif

// File: design/pwm_cycle_pkg.sv
// Types for the counter array PWM cycle configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package pwm_cycle_pkg;
  typedef enum logic [1:0] {
    len_8bit,
    len_9bit,
    len_10bit,
    len_11bit
  } cycle_len_t;
endpackage

// File: design/chan_cfg_if.sv
// Interface between the configuration top and the per-channel cycle logic.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface chan_cfg_if #(parameter int NCH = 3);
  logic [1:0] len_sel;
  logic [NCH-1:0] wide_sel;
  logic [NCH-1:0] pwm_en;
  logic [NCH-1:0] reload_used;
  logic [NCH-1:0][3:0] cycle_bits;
  modport cfg (output len_sel, output wide_sel, output pwm_en,
               input reload_used, input cycle_bits);
  modport chan (input len_sel, input wide_sel, input pwm_en,
                output reload_used, output cycle_bits);
endinterface
`default_nettype wire

// File: design/chan_cycle.sv
// Per-channel cycle length and reload usage decode.
// Assumes the channel mode bits come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cycle_consts.svh"
module chan_cycle
  import pwm_cycle_pkg::*;
#(
  parameter int NCH = 3
) (
  chan_cfg_if.chan cfg
);
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      // Wide channels ignore the shared length select
      assign cfg.cycle_bits[i] = cfg.wide_sel[i] ? 4'h0 :
        4'(`BASE_CYCLE_BITS + cfg.len_sel); // R8 R9
      // Reload value only matters for 9 to 11 bit cycles
      assign cfg.reload_used[i] = cfg.pwm_en[i] && !cfg.wide_sel[i] &&
        (cycle_len_t'(cfg.len_sel) != len_8bit); // R2
    end
  endgenerate
endmodule
`default_nettype wire

// File: tb/pwm_cycle_asserts.sv
// Checker for the PWM cycle configuration register.
// Assumes a bind to the block's top; channel 0 stands for all.
`timescale 1ns/1ps
`default_nettype none
module pwm_cycle_asserts #(parameter int NCH = 3) (
  // Clock, reset, register port
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Counter and modes
  input wire logic [15:0] counter_value,
  input wire logic counter_tick,
  input wire logic [NCH-1:0] chan_pwm_en,
  input wire logic [NCH-1:0] wide_pwm_select,
  // Outputs
  input wire logic reload_reg_select,
  input wire logic [1:0] cycle_length_select,
  input wire logic [NCH-1:0][3:0] chan_cycle_bits,
  input wire logic [NCH-1:0] chan_reload_used,
  input wire logic cycle_ovf,
  input wire logic cycle_ovf_irq
);
  // ----
  // Checks
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic hit = reg_wr && reg_addr == 8'hf7;
  wire logic [15:0] low_mask = (16'h0100 << cycle_length_select) - 16'h0001;
  wire logic ovf_due = counter_tick && ((counter_value & low_mask) == low_mask);
  a_irq_mask: assert property (hit && !reg_wdata[6] |=> !cycle_ovf_irq)
    else $error("irq with enable low");
  a_flag_clear: assert property ($fell(cycle_ovf) |-> $past(hit) && !$past(reg_wdata[5]))
    else $error("flag cleared by itself");
  a_unused_zero: assert property (reg_addr == 8'hf7 |-> reg_rdata[4:2] == 3'h0)
    else $error("unused bits not zero");
  a_other_addr: assert property (reg_wr && reg_addr != 8'hf7 |=> $stable(reload_reg_select))
    else $error("foreign write changed select");
  a_len_write: assert property (hit |=> cycle_length_select == $past(reg_wdata[1:0]))
    else $error("length not written");
  a_ovf_set: assert property (counter_tick && counter_value[7:0] == 8'hff &&
    cycle_length_select == 2'h0 |=> cycle_ovf) else $error("no overflow flag");
  a_cycle_len: assert property (chan_cycle_bits[0] == (wide_pwm_select[0] ? 4'h0 :
    4'h8 + cycle_length_select)) else $error("cycle bits wrong");
  a_reload_use: assert property (chan_reload_used[0] == (chan_pwm_en[0] &&
    !wide_pwm_select[0] && cycle_length_select != 2'h0)) else $error("reload use wrong");
  a_ovf_any: assert property (ovf_due |=> cycle_ovf)
    else $error("no overflow flag for length");
  a_flag_rise: assert property ($rose(cycle_ovf) |-> $past(ovf_due) ||
    ($past(hit) && $past(reg_wdata[5]))) else $error("flag set without cause");
  a_irq_level: assert property (reg_addr == 8'hf7 |-> cycle_ovf_irq ==
    (reg_rdata[5] && reg_rdata[6])) else $error("irq level wrong");
endmodule
bind pwm_cycle_length_config pwm_cycle_asserts #(.NCH(NCH)) u_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .counter_value(counter_value),
  .counter_tick(counter_tick),
  .chan_pwm_en(chan_pwm_en),
  .wide_pwm_select(wide_pwm_select),
  .reload_reg_select(reload_reg_select),
  .cycle_length_select(cycle_length_select),
  .chan_cycle_bits(chan_cycle_bits),
  .chan_reload_used(chan_reload_used),
  .cycle_ovf(cycle_ovf),
  .cycle_ovf_irq(cycle_ovf_irq)
);
`default_nettype wire

// File: tb/tb_pwm_cycle_length_config.sv
// Self-checking bench for the PWM cycle configuration register.
// Assumes design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_pwm_cycle_length_config;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, counter_tick = 0, look = 0;
  logic sel, ovf, irq;
  logic [1:0] len;
  logic [7:0] reg_addr = 8'hf7, reg_wdata = 8'h00, reg_rdata, d, x;
  logic [15:0] counter_value = 16'h0000;
  logic [2:0] chan_pwm_en = 3'h0, wide_pwm_select = 3'h0, reload_used;
  logic [2:0][3:0] cyc;
  logic [22:0] q[$], e;
  int errors = 0, checked = 0;
  pwm_cycle_length_config dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .counter_value(counter_value), .counter_tick(counter_tick), .chan_pwm_en(chan_pwm_en),
    .wide_pwm_select(wide_pwm_select), .reload_reg_select(sel), .cycle_length_select(len),
    .chan_cycle_bits(cyc), .chan_reload_used(reload_used), .cycle_ovf(ovf),
    .cycle_ovf_irq(irq));
  // ----
  // Drivers and monitor
  // ----
  initial forever #4 core_clk = ~core_clk;
  task close_out;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
    reg_addr = 8'hf7;
  endtask
  // Expected read byte, cycle lengths and reload use of every channel
  task automatic note(input logic [7:0] v);
    logic [11:0] c;
    logic [2:0] r;
    for (int k = 0; k < 3; k++) begin
      c[k*4 +: 4] = wide_pwm_select[k] ? 4'h0 : 4'h8 + {2'b00, v[1:0]};
      r[k] = chan_pwm_en[k] && !wide_pwm_select[k] && v[1:0] != 2'b00;
    end
    q.push_back({v, c, r});
    look = 1;
    @(negedge core_clk);
    look = 0;
  endtask
  always @(posedge core_clk) if (look) begin
    e = q.pop_front();
    x = e[22:15];
    `CHK("rdata", x, reg_rdata)
    `CHK("cycle", e[14:3], cyc)
    `CHK("reload", e[2:0], reload_used)
    `CHK("sel", x[7], sel)
    `CHK("len", x[1:0], len)
    `CHK("ovf", x[5], ovf)
    `CHK("irq", x[6] & x[5], irq)
  end
  initial begin
    void'($urandom(32'h6859));
    repeat (20) @(negedge core_clk);
    rst_b = 1;
    note(8'h00);
    for (int i = 0; i < 4; i++) begin
      wide_pwm_select = 3'($urandom);
      chan_pwm_en = 3'($urandom);
      d = 8'($urandom) & 8'h1c | 8'(i) | 8'(i[0]) << 6 | 8'(i[1]) << 7;
      wr(8'hf7, d);
      note(d & 8'hc3);
      wr(8'hf6, 8'hff);
      note(d & 8'hc3);
      counter_value = 16'((17'h1 << (8 + i)) - 17'h1);
      counter_tick = 1;
      @(negedge core_clk);
      counter_tick = 0;
      note(d & 8'hc3 | 8'h20);
    end
    wr(8'hf7, 8'h40);
    note(8'h40);
    // Overflow and a clearing write on one edge: the set wins
    counter_value = 16'h00ff;
    counter_tick = 1;
    wr(8'hf7, 8'h40);
    counter_tick = 0;
    note(8'h60);
    rst_b = 0;
    repeat (2) @(negedge core_clk);
    rst_b = 1;
    note(8'h00);
    wr(8'hf7, 8'h20);
    note(8'h20);
    close_out();
  end
endmodule
`default_nettype wire
